// *** verilog/mode_bank_consts.svh ***
// constants of the mode register bank: addresses, field positions, codes, reset values, timing
// assumes inclusion by the design modules; the package does not include it
//
// Overview of operation
// - write-only latency register 02H; low nibble codes 0010..0111 pick read/write latency
// - write-only drive strength at 03H; 0001..0111 valid, 0101 reserved, default 0010
// - read-only refresh-rate code in bits 2:0 of the temperature register 04H
// - update flag bit 7 sets when the refresh-rate code changes since last read
// - reading the temperature register clears its update flag
// - update flag is zero after power-up
// - refresh-rate code bit 2 set means the die is above 85 degrees
// - address 05H reads an eight-bit maker identification
// - address 06H reads the first revision identifier
// - address 07H reads the second revision identifier
// - address 08H reads type in 1:0, density in 5:2, bus width in 7:6
// - address 09H is the vendor test-mode register, undefined in normal use
// - writing 0AH picks init, long, short calibration or calibration reset
// - a reserved calibration value is ignored and starts nothing
// - reference pin at core supply forces default calibration, commands ignored
// - init calibration completion records the reference resistor connection in register 0
// - register 0 bits 4:3 hold self test: 00 none, 01 supply/open, 10 ground, 11 good
`ifndef MODE_BANK_CONSTS_SVH
`define MODE_BANK_CONSTS_SVH

`define MA_DEVICE_INFO    8'h00
`define MA_LATENCY        8'h02
`define MA_IO_DRIVE       8'h03
`define MA_TEMPERATURE    8'h04
`define MA_MAKER_ID       8'h05
`define MA_REVISION_1     8'h06
`define MA_REVISION_2     8'h07
`define MA_GEOMETRY       8'h08
`define MA_TEST_MODE      8'h09
`define MA_CALIBRATION    8'h0A

`define LAT_CODE_MIN      4'h2
`define LAT_CODE_MAX      4'h7
`define LAT_RESET         4'h2
`define RL_BASE           4'h3

`define DS_CODE_MIN       4'h1
`define DS_CODE_MAX       4'h7
`define DS_CODE_RSVD      4'h5
`define DS_RESET          4'h2

`define TUF_BIT           7
`define HOT_BIT           2

`define CAL_CODE_INIT     8'hFF
`define CAL_CODE_LONG     8'hAB
`define CAL_CODE_SHORT    8'h56
`define CAL_CODE_RESET    8'hC3

`define SELFTEST_NONE     2'h0
`define SELFTEST_SUPPLY   2'h1
`define SELFTEST_GROUND   2'h2
`define SELFTEST_GOOD     2'h3
`define SELFTEST_LSB      3

`define GEO_TYPE          2'h0
`define GEO_DENSITY       4'h5
`define GEO_WIDTH_X32     2'h0
`define GEO_WIDTH_X16     2'h1

`define CLOCK_PERIOD_NS   10
`define CAL_INIT_NS       1000
`define CAL_LONG_NS       360
`define CAL_SHORT_NS      90
`define CAL_RESET_NS      50

`endif

// *** verilog/mode_bank_pkg.sv ***
// types shared by the mode register bank modules
// assumes the constants header sits beside it
package mode_bank_pkg;

    typedef enum logic [2:0] {
        CAL_NONE,
        CAL_INIT,
        CAL_LONG,
        CAL_SHORT,
        CAL_RESET
    } calib_op_type;

    typedef struct packed {
        logic       select_b;
        logic       write;
        logic [7:0] addr;
        logic [7:0] data;
    } mode_cmd_type;

    typedef struct packed {
        logic         link_clk;
        mode_cmd_type cmd;
        logic [2:0]   sensor_code;
        logic         ref_at_supply;
        logic         ref_at_ground;
    } pin_bundle_type;

endpackage

// *** verilog/pin_sync.sv ***
// two-stage synchroniser for a bundle of pin inputs
// assumes the pins are asynchronous to clock
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) $error("pin_sync width must be at least one");
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// *** verilog/calib_engine.sv ***
// calibration sequencer: runs one calibration operation for its set duration
// assumes start is a one-cycle pulse on clock, only given while idle
`timescale 1ns/1ns
`include "mode_bank_consts.svh"
module calib_engine
    import mode_bank_pkg::*;
#(
    parameter int INIT_NS  = `CAL_INIT_NS,
    parameter int LONG_NS  = `CAL_LONG_NS,
    parameter int SHORT_NS = `CAL_SHORT_NS,
    parameter int RESET_NS = `CAL_RESET_NS
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         start,
    input  wire calib_op_type start_op,
    output logic              busy,
    output logic              done,
    output calib_op_type      done_op
);
    localparam int INIT_CYC  = (INIT_NS  + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
    localparam int LONG_CYC  = (LONG_NS  + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
    localparam int SHORT_CYC = (SHORT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;
    localparam int RESET_CYC = (RESET_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS;

    typedef enum logic {ST_IDLE, ST_RUN} cal_state_type;

    cal_state_type state_q;
    calib_op_type  op_q;
    logic [11:0]   count_q;
    logic [11:0]   load_count;

    initial begin
        if (INIT_CYC < 1 || INIT_CYC > 4095 || LONG_CYC < 1 || LONG_CYC > 4095 ||
            SHORT_CYC < 1 || SHORT_CYC > 4095 || RESET_CYC < 1 || RESET_CYC > 4095)
            $error("calibration durations out of range");
    end

    assign load_count = (start_op == CAL_INIT)  ? 12'(INIT_CYC)  :
                        (start_op == CAL_LONG)  ? 12'(LONG_CYC)  :
                        (start_op == CAL_SHORT) ? 12'(SHORT_CYC) : 12'(RESET_CYC);
    assign busy = (state_q == ST_RUN);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            op_q    <= CAL_NONE;
            count_q <= 12'h000;
            done    <= 1'b0;
            done_op <= CAL_NONE;
        end else begin
            done <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_RUN;
                        op_q    <= start_op;
                        count_q <= load_count;
                    end
                end
                ST_RUN: begin
                    if (count_q == 12'h001) begin
                        state_q <= ST_IDLE;
                        done    <= 1'b1;
                        done_op <= op_q;
                    end
                    count_q <= count_q - 12'h001;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** verilog/mode_register_bank.sv ***
// mode register bank: decodes mode register write and read commands from the
// command pins, holds latency, drive strength, temperature status and calibration
// assumes command pins are sampled at rising edges of the link clock pin,
// which runs well below half the block clock
`timescale 1ns/1ns
`include "mode_bank_consts.svh"
module mode_register_bank
    import mode_bank_pkg::*;
#(
    parameter logic [7:0] MAKER_ID   = 8'h5A,
    parameter logic [7:0] REVISION_1 = 8'h01,
    parameter logic [7:0] REVISION_2 = 8'h02,
    parameter bit         BUS_X16    = 1'b1,
    parameter int         CAL_INIT_NS = `CAL_INIT_NS
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       link_clk_pin,
    input  wire logic       cmd_select_b_pin,
    input  wire logic       cmd_write_pin,
    input  wire logic [7:0] mode_addr_pin,
    input  wire logic [7:0] op_data_pin,
    input  wire logic [2:0] sensor_code_pin,
    input  wire logic       ref_at_supply_pin,
    input  wire logic       ref_at_ground_pin,
    output logic      [7:0] read_data,
    output logic            read_valid,
    output logic      [3:0] read_latency,
    output logic      [3:0] write_latency,
    output logic      [3:0] drive_strength,
    output logic      [2:0] refresh_code,
    output logic            temp_update_flag,
    output logic            calib_busy,
    output logic            calib_default
);
    // MAKER_ID, REVISION_1, REVISION_2 defaults are arbitrary

    pin_bundle_type pins_raw;
    pin_bundle_type pins_s;
    logic           link_clk_prev_q;
    logic           link_rise;
    logic           cmd_taken;
    logic           wr_taken;
    logic           rd_taken;
    logic [3:0]     wr_nibble;

    logic [3:0]     lat_code_q;
    logic [3:0]     ds_code_q;
    logic [2:0]     temp_code_q;
    logic           tuf_q;
    logic [1:0]     selftest_q;

    logic           lat_code_ok;
    logic           ds_code_ok;
    logic           cal_code_ok;
    calib_op_type   cal_op_dec;
    logic           cal_start;
    logic           cal_busy_w;
    logic           cal_done;
    calib_op_type   cal_done_op;
    logic           code_changed;
    logic           tuf_clear;
    logic [1:0]     ref_selftest;
    logic [1:0]     geo_width;
    logic [7:0]     temp_value;
    logic [7:0]     info_value;
    logic [7:0]     geo_value;
    logic [7:0]     rd_value;
    logic [3:0]     wl_of_code;
    logic [1:0]     fill_q;
    logic           sync_ready;
    logic           lat_write;
    logic           ds_write;
    logic           init_at_supply;

    assign pins_raw.link_clk      = link_clk_pin;
    assign pins_raw.cmd.select_b  = cmd_select_b_pin;
    assign pins_raw.cmd.write     = cmd_write_pin;
    assign pins_raw.cmd.addr      = mode_addr_pin;
    assign pins_raw.cmd.data      = op_data_pin;
    assign pins_raw.sensor_code   = sensor_code_pin;
    assign pins_raw.ref_at_supply = ref_at_supply_pin;
    assign pins_raw.ref_at_ground = ref_at_ground_pin;

    pin_sync #(
        .WIDTH ($bits(pin_bundle_type))
    ) u_pin_sync (
        .clock (clock),
        .rst_b (rst_b),
        .d     (pins_raw),
        .q     (pins_s)
    );

    // synchroniser holds real pin values from the second edge after reset
    assign sync_ready = (fill_q == 2'h2);

    // command is taken at each synchronised rising edge of the link clock while select_b is low
    assign link_rise = sync_ready & pins_s.link_clk & ~link_clk_prev_q;
    assign cmd_taken = link_rise & ~pins_s.cmd.select_b;
    assign wr_taken  = cmd_taken & pins_s.cmd.write;
    assign rd_taken  = cmd_taken & ~pins_s.cmd.write;
    assign wr_nibble = pins_s.cmd.data[3:0];

    // latency codes: reserved ones are dropped
    assign lat_code_ok = (wr_nibble >= `LAT_CODE_MIN) && (wr_nibble <= `LAT_CODE_MAX);

    // drive strength codes, 0101 is reserved
    assign ds_code_ok = (wr_nibble >= `DS_CODE_MIN) && (wr_nibble <= `DS_CODE_MAX)
                        && (wr_nibble != `DS_CODE_RSVD);

    // register write strobes
    assign lat_write      = wr_taken && (pins_s.cmd.addr == `MA_LATENCY) && lat_code_ok;
    assign ds_write       = wr_taken && (pins_s.cmd.addr == `MA_IO_DRIVE) && ds_code_ok;
    assign init_at_supply = wr_taken && (pins_s.cmd.addr == `MA_CALIBRATION)
                            && (cal_op_dec == CAL_INIT) && pins_s.ref_at_supply;

    // calibration command decode
    assign cal_op_dec = (pins_s.cmd.data == `CAL_CODE_INIT)  ? CAL_INIT  :
                        (pins_s.cmd.data == `CAL_CODE_LONG)  ? CAL_LONG  :
                        (pins_s.cmd.data == `CAL_CODE_SHORT) ? CAL_SHORT :
                        (pins_s.cmd.data == `CAL_CODE_RESET) ? CAL_RESET : CAL_NONE;
    assign cal_code_ok = (cal_op_dec != CAL_NONE);

    // pin tied to supply: default calibration, commands ignored
    assign cal_start = wr_taken && (pins_s.cmd.addr == `MA_CALIBRATION) && cal_code_ok
                       && !pins_s.ref_at_supply && !cal_busy_w;

    assign ref_selftest = pins_s.ref_at_supply ? `SELFTEST_SUPPLY :
                          pins_s.ref_at_ground ? `SELFTEST_GROUND : `SELFTEST_GOOD;

    calib_engine #(
        .INIT_NS  (CAL_INIT_NS),
        .LONG_NS  (`CAL_LONG_NS),
        .SHORT_NS (`CAL_SHORT_NS),
        .RESET_NS (`CAL_RESET_NS)
    ) u_calib_engine (
        .clock    (clock),
        .rst_b    (rst_b),
        .start    (cal_start),
        .start_op (cal_op_dec),
        .busy     (cal_busy_w),
        .done     (cal_done),
        .done_op  (cal_done_op)
    );

    // temperature status
    assign code_changed = (pins_s.sensor_code != temp_code_q);
    assign tuf_clear    = rd_taken && (pins_s.cmd.addr == `MA_TEMPERATURE);
    assign temp_value   = {tuf_q, 4'h0, temp_code_q};

    // geometry and register 0
    assign geo_width  = BUS_X16 ? `GEO_WIDTH_X16 : `GEO_WIDTH_X32;
    assign geo_value  = {geo_width, `GEO_DENSITY, `GEO_TYPE};
    assign info_value = {3'h0, selftest_q, 3'h0};

    // write latency pairs with the read latency code
    always_comb begin
        case (lat_code_q)
            4'h2:    wl_of_code = 4'h1;
            4'h3:    wl_of_code = 4'h2;
            4'h4:    wl_of_code = 4'h2;
            4'h5:    wl_of_code = 4'h3;
            4'h6:    wl_of_code = 4'h4;
            4'h7:    wl_of_code = 4'h4;
            default: wl_of_code = 4'h1;
        endcase
    end

    // read data mux; write-only and test mode addresses read zero
    always_comb begin
        case (pins_s.cmd.addr)
            `MA_DEVICE_INFO: rd_value = info_value;
            `MA_TEMPERATURE: rd_value = temp_value;
            `MA_MAKER_ID:    rd_value = MAKER_ID;
            `MA_REVISION_1:  rd_value = REVISION_1;
            `MA_REVISION_2:  rd_value = REVISION_2;
            `MA_GEOMETRY:    rd_value = geo_value;
            `MA_TEST_MODE:   rd_value = 8'h00;
            default:         rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            link_clk_prev_q <= 1'b0;
        end else begin
            link_clk_prev_q <= pins_s.link_clk;
        end
    end

    // counts the edges the synchroniser needs to fill after reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fill_q <= 2'h0;
        end else if (!sync_ready) begin
            fill_q <= fill_q + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lat_code_q <= `LAT_RESET;
            ds_code_q  <= `DS_RESET;
        end else begin
            if (lat_write)
                lat_code_q <= wr_nibble;
            if (ds_write)
                ds_code_q <= wr_nibble;
        end
    end

    // flag: a change in the same cycle as the read wins over the clear;
    // the code is not followed until the synchroniser holds pin values,
    // so the synchroniser's reset zeros never look like a code change
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            temp_code_q <= 3'h3;
            tuf_q       <= 1'b0;
        end else if (sync_ready) begin
            temp_code_q <= pins_s.sensor_code;
            if (code_changed)
                tuf_q <= 1'b1;
            else if (tuf_clear)
                tuf_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            selftest_q <= `SELFTEST_NONE;
        end else begin
            if (cal_done && cal_done_op == CAL_INIT)
                selftest_q <= ref_selftest;
            else if (init_at_supply)
                selftest_q <= `SELFTEST_SUPPLY;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            read_data  <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            read_valid <= rd_taken;
            if (rd_taken)
                read_data <= rd_value;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            read_latency     <= `RL_BASE;
            write_latency    <= 4'h1;
            drive_strength   <= `DS_RESET;
            refresh_code     <= 3'h3;
            temp_update_flag <= 1'b0;
            calib_busy       <= 1'b0;
            calib_default    <= 1'b0;
        end else begin
            read_latency     <= lat_code_q + 4'h1;
            write_latency    <= wl_of_code;
            drive_strength   <= ds_code_q;
            refresh_code     <= temp_code_q;
            temp_update_flag <= tuf_q;
            calib_busy       <= cal_busy_w;
            calib_default    <= pins_s.ref_at_supply;
        end
    end
endmodule

// *** bench/mode_bank_props.sv ***
// checker on the ports of the mode register bank
// assumes one clock domain with rst_b asynchronous and active low
`timescale 1ns/1ns
module mode_bank_props #(
    parameter int CAL_INIT_NS = 1000
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [2:0] sensor_code_pin,
    input  wire logic       ref_at_supply_pin,
    input  wire logic [7:0] read_data,
    input  wire logic       read_valid,
    input  wire logic [3:0] read_latency,
    input  wire logic [3:0] write_latency,
    input  wire logic [3:0] drive_strength,
    input  wire logic [2:0] refresh_code,
    input  wire logic       temp_update_flag,
    input  wire logic       calib_busy,
    input  wire logic       calib_default
);
    localparam int CAL_MAX = CAL_INIT_NS / 10 + 40;
    wire logic [3:0] wl_exp;
    // write latency paired with each read latency
    assign wl_exp = (read_latency < 4'h4) ? 4'h1 : (read_latency < 4'h6) ? 4'h2 :
                    (read_latency == 4'h6) ? 4'h3 : 4'h4;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_cal_min;
        calib_busy [*4];
    endsequence
    sequence s_cal_end;
        ##[1:CAL_MAX] !calib_busy;
    endsequence
    property p_flag_reset;
        $rose(rst_b) |-> (!temp_update_flag) [*4];
    endproperty
    property p_flag_clear;
        $fell(temp_update_flag) |-> $past(read_valid);
    endproperty
    property p_flag_set;
        $changed(refresh_code) |-> ##[0:2] temp_update_flag;
    endproperty
    property p_code_follow;
        ($stable(sensor_code_pin)) [*6] |-> refresh_code == sensor_code_pin;
    endproperty
    property p_read_hold;
        !read_valid |-> $stable(read_data);
    endproperty
    property p_read_pulse;
        read_valid |=> !read_valid;
    endproperty
    property p_latency_pair;
        read_latency inside {[4'h3:4'h8]} && write_latency == wl_exp;
    endproperty
    property p_drive_legal;
        drive_strength inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
    endproperty
    property p_supply_block;
        ref_at_supply_pin [*4] |-> !$rose(calib_busy);
    endproperty
    property p_default_on;
        ref_at_supply_pin [*6] |-> calib_default;
    endproperty
    property p_cal_run;
        $rose(calib_busy) |-> s_cal_min ##0 s_cal_end;
    endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("flag set after reset");
    a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without read");
    a_flag_set: assert property (p_flag_set) else $error("flag missed a code change");
    a_code_follow: assert property (p_code_follow) else $error("refresh code stale");
    a_read_hold: assert property (p_read_hold) else $error("read data moved");
    a_read_pulse: assert property (p_read_pulse) else $error("read valid too long");
    a_latency_pair: assert property (p_latency_pair) else $error("latency pair bad");
    a_drive_legal: assert property (p_drive_legal) else $error("drive code bad");
    a_supply_block: assert property (p_supply_block) else $error("calibration at supply");
    a_default_on: assert property (p_default_on) else $error("default calibration off");
    a_cal_run: assert property (p_cal_run) else $error("calibration length bad");
endmodule
bind mode_register_bank mode_bank_props #(.CAL_INIT_NS(CAL_INIT_NS)) i_props (
    .clock(clock), .rst_b(rst_b), .sensor_code_pin(sensor_code_pin),
    .ref_at_supply_pin(ref_at_supply_pin), .read_data(read_data), .read_valid(read_valid),
    .read_latency(read_latency), .write_latency(write_latency), .drive_strength(drive_strength),
    .refresh_code(refresh_code), .temp_update_flag(temp_update_flag), .calib_busy(calib_busy),
    .calib_default(calib_default)
);

// *** bench/mode_ctrl_model.sv ***
// memory controller model issuing mode register commands on the pins
// assumes pins are sampled at link clock rising edges; link clock idles low
`timescale 1ns/1ns
module mode_ctrl_model (
    input  wire logic       clock,
    output logic            link_clk,
    output logic            select_b,
    output logic            write,
    output logic      [7:0] addr,
    output logic      [7:0] data
);
    initial begin
        link_clk = 1'b0;
        select_b = 1'b1;
        write    = 1'b0;
        addr     = 8'h00;
        data     = 8'h00;
    end
    // one command per link period, pins held across the rising edge
    task automatic issue(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        select_b = 1'b0; // mode commands only, never a burst
        write    = wr;
        addr     = a;
        data     = d;
        #62 link_clk = 1'b1;
        #63 link_clk = 1'b0;
        @(negedge clock);
        select_b = 1'b1;
        write    = ~wr;
        addr     = ~a;
        data     = ~d;
    endtask
endmodule

// *** bench/mode_register_bank_tb.sv ***
// testbench for the mode register bank: controller model on the pins, one task per scenario
// assumes the design, the checker and the controller model are compiled before it
`timescale 1ns/1ns
module mode_register_bank_tb;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [7:0] REV_A = 8'h11; // arbitrary value
    localparam logic [7:0] REV_B = 8'h22; // arbitrary value
    logic       clock, rst_b, link_clk, select_b, wr_pin, sup, gnd;
    logic       read_valid, flag, busy, dflt, busy_q;
    logic [7:0] addr, data, read_data, last_rd;
    logic [2:0] sensor, refresh_code;
    logic [3:0] rl, wl, ds;
    int         err_count = 0, checks_done = 0, rd_n = 0, busy_n = 0, cycles = 0;

    mode_register_bank #(.MAKER_ID(MAKER), .REVISION_1(REV_A), .REVISION_2(REV_B),
        .BUS_X16(1'b1), .CAL_INIT_NS(50)) i_dut (
        .clock(clock), .rst_b(rst_b), .link_clk_pin(link_clk), .cmd_select_b_pin(select_b),
        .cmd_write_pin(wr_pin), .mode_addr_pin(addr), .op_data_pin(data),
        .sensor_code_pin(sensor), .ref_at_supply_pin(sup), .ref_at_ground_pin(gnd),
        .read_data(read_data), .read_valid(read_valid), .read_latency(rl), .write_latency(wl),
        .drive_strength(ds), .refresh_code(refresh_code), .temp_update_flag(flag),
        .calib_busy(busy), .calib_default(dflt));
    mode_ctrl_model i_ctrl (.clock(clock), .link_clk(link_clk), .select_b(select_b),
        .write(wr_pin), .addr(addr), .data(data));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // capture read answers and calibration starts, cut hangs short
    always @(negedge clock) begin
        cycles++;
        if (read_valid === 1'b1) begin
            last_rd = read_data;
            rd_n++;
        end
        if (busy === 1'b1 && busy_q !== 1'b1) busy_n++;
        busy_q = busy;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int n0;
        n0 = rd_n;
        i_ctrl.issue(1'b0, a, 8'h00);
        for (int k = 0; k < 20 && rd_n == n0; k++) @(negedge clock);
        v = (rd_n == n0) ? 8'hXX : last_rd;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_ctrl.issue(1'b1, a, d);
        repeat (3) @(negedge clock);
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clock);
        chk("calib_busy", 8'h00, {7'h00, busy});
    endtask
    task automatic t_reset;
        chk("read_latency", 8'h03, {4'h0, rl});
        chk("write_latency", 8'h01, {4'h0, wl});
        chk("drive_strength", 8'h02, {4'h0, ds});
        chk("temp_update_flag", 8'h00, {7'h00, flag});
        $display("test reset done");
    endtask
    task automatic t_ids;
        logic [7:0] a [8] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h02, 8'h00};
        logic [7:0] e [8] = '{MAKER, REV_A, REV_B, 8'h54, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            rd(a[i], v);
            chk("read data", e[i], v);
        end
        $display("test ids done");
    endtask
    task automatic t_latency;
        logic [3:0] wl_t [9] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4};
        logic [3:0] exp;
        exp = 4'h3;
        for (int c = 1; c <= 8; c++) begin
            wr(8'h02, 8'(c));
            if (c >= 2 && c <= 7) exp = 4'(c + 1);
            chk("read_latency", {4'h0, exp}, {4'h0, rl});
            chk("write_latency", {4'h0, wl_t[exp]}, {4'h0, wl});
        end
        $display("test latency done");
    endtask
    task automatic t_drive;
        logic [3:0] exp;
        exp = 4'h2;
        for (int c = 0; c < 16; c++) begin
            wr(8'h03, 8'(c));
            if (c >= 1 && c <= 7 && c != 5) exp = 4'(c);
            chk("drive_strength", {4'h0, exp}, {4'h0, ds});
        end
        $display("test drive done");
    endtask
    task automatic t_temp;
        logic [7:0] v;
        rd(8'h04, v);
        for (int c = 0; c < 8; c++) begin
            sensor = 3'(c);
            repeat (8) @(negedge clock);
            chk("refresh_code", {5'h00, 3'(c)}, {5'h00, refresh_code});
            chk("temp_update_flag", 8'h01, {7'h00, flag});
            rd(8'h04, v);
            chk("temperature read", {1'b1, 4'h0, 3'(c)}, v);
            rd(8'h04, v);
            chk("temperature reread", {1'b0, 4'h0, 3'(c)}, v);
        end
        $display("test temperature done");
    endtask
    task automatic t_calib;
        logic [7:0] codes [4] = '{8'hAB, 8'h56, 8'hC3, 8'hFF};
        logic [7:0] v;
        int n0;
        n0 = busy_n;
        wr(8'h0A, 8'h12);
        repeat (10) @(negedge clock);
        chk("calibration starts", 8'(n0), 8'(busy_n));
        for (int i = 0; i < 4; i++) begin
            n0 = busy_n;
            wr(8'h0A, codes[i]);
            wait_idle();
            chk("calibration starts", 8'(n0 + 1), 8'(busy_n));
        end
        rd(8'h00, v);
        chk("self test", 8'h18, v);
        gnd = 1'b1;
        wr(8'h0A, 8'hFF);
        wait_idle();
        rd(8'h00, v);
        chk("self test", 8'h10, v);
        gnd = 1'b0;
        sup = 1'b1;
        repeat (10) @(negedge clock);
        chk("calib_default", 8'h01, {7'h00, dflt});
        n0 = busy_n;
        wr(8'h0A, 8'hAB);
        wr(8'h0A, 8'hFF);
        repeat (10) @(negedge clock);
        chk("calibration starts", 8'(n0), 8'(busy_n));
        rd(8'h00, v);
        chk("self test", 8'h08, v);
        $display("test calibration done");
    endtask
    initial begin
        rst_b  = 1'b0;
        sensor = 3'h3;
        sup    = 1'b0;
        gnd    = 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        t_reset();
        t_ids();
        t_latency();
        t_drive();
        t_temp();
        t_calib();
        final_report();
    end
endmodule
